/* verilog/nvm_ctrl_pkg.sv */
package nvm_ctrl_pkg;
   // ------------------------------------------------------------
   // Key values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PWRT_MS = 64;
   localparam int PWRT_CYCLES = PWRT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int ERASE_MS = 2;
   localparam int ERASE_CYCLES = ERASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int EE_WRITE_US = 4;
   localparam int EE_WRITE_CYCLES = EE_WRITE_US * 1000 / CLK_PERIOD_NS;
   localparam int SETUP_CYCLES = 2;
   // ------------------------------------------------------------
   // Memory organisation
   // ------------------------------------------------------------
   localparam int EE_DEPTH = 256;
   localparam int PM_DEPTH = 512;
   localparam int PM_AW = 9;
   localparam int ROW_WORDS = 32;
   localparam int ROW_LSB = 5;
   localparam logic [13:0] ERASED_WORD = 14'h3FFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [1:0] GUARD_NONE = 2'h3;
   localparam logic [1:0] GUARD_QUARTER = 2'h2;
   localparam logic [1:0] GUARD_HALF = 2'h1;

   // Register write strobes from the CPU side
   typedef struct packed {
      logic key_we;
      logic [7:0] key_data;
      logic ctl_we;
      logic set_trigger;
      logic set_fetch;
      logic permit;
      logic space_sel;
      logic cfg_sel;
      logic row_clear;
      logic clear_done;
      logic clear_error;
      logic addr_lo_we;
      logic addr_hi_we;
      logic data_lo_we;
      logic data_hi_we;
      logic [7:0] wdata;
   } cpu_wr_s;

   // Control and status bits seen by software
   typedef struct packed {
      logic program_trigger;
      logic fetch_trigger;
      logic program_permit;
      logic program_space_select;
      logic config_space_select;
      logic row_clear_select;
      logic program_done_flag;
      logic interrupted_program_error;
   } nvm_status_s;

   typedef enum {ST_IDLE, ST_SETUP, ST_BUSY, ST_FETCH} nvm_state_e;
endpackage

/* verilog/nvm_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Byte write starts only after 55h, AAh to key, then trigger.
// - Trigger cannot be set while permit is clear.
// - Hardware never clears permit; only software, power-up or device reset.
// - Clearing permit mid-write does not disturb the write.
// - Write end clears trigger and sets the done flag.
// - Done flag stays set until software clears it.
// - Power-up clears permit.
// - Power-up timer of 64 ms blocks data writes.
// - Data protect low denies programmer access to data memory.
// - Program write or erase only outside the guarded segment.
// - Program data staged in hidden 14-bit latches via data regs.
// - Rows and latch sets are 32 words, aligned on five low bits.
// - Read uses the second cycle after fetch, data next cycle.
// - Data registers hold read word until next read or write.
// - Program reads ignore the code guard.
// - Row clear select drops when erase completes.
// - Erase: two setup cycles, 2 ms stall, resume third instruction.
// - Space select low picks data memory; data after reset.
// - Triggers are set by software only, cleared by hardware.
// - Reset during a write sets the interrupted error flag.
// - Data byte write overwrites the byte directly, with no erase step.
module nvm_ctrl
#(
   parameter int PWRT_CNT = nvm_ctrl_pkg::PWRT_CYCLES,
   parameter int ERASE_CNT = nvm_ctrl_pkg::ERASE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire nvm_ctrl_pkg::cpu_wr_s cpu_wr,
   input wire logic [1:0] self_program_guard,
   input wire logic data_protect_n,
   input wire logic code_guard_n,
   input wire logic ext_read_req,
   input wire logic [7:0] ext_addr,
   output nvm_ctrl_pkg::nvm_status_s status,
   output logic [7:0] nvm_data_low,
   output logic [5:0] nvm_data_high,
   output logic [7:0] nvm_addr_low,
   output logic [6:0] nvm_addr_high,
   output logic cpu_stall,
   output logic [7:0] ext_read_data,
   output logic ext_read_denied
);
   import nvm_ctrl_pkg::*;

   // ------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------
   logic [7:0] ee_mem [EE_DEPTH];
   logic [13:0] pm_mem [PM_DEPTH];
   logic [13:0] latch_mem [ROW_WORDS];
   nvm_state_e state_reg, state_next;
   nvm_status_s st_reg, st_next;
   logic [1:0] key_reg, key_next;
   logic [22:0] cnt_reg, cnt_next;
   logic pwrt_done_reg, pwrt_done_next;
   logic [22:0] pwrt_reg, pwrt_next;
   logic active_reg;
   logic active_next_w;
   logic flag_err_reg;
   logic [7:0] dlo_reg, dlo_next;
   logic [5:0] dhi_reg, dhi_next;
   logic [7:0] alo_reg, alo_next;
   logic [6:0] ahi_reg, ahi_next;
   logic stall_reg, stall_next;
   logic [7:0] xd_reg, xd_next;
   logic xden_reg, xden_next;
   logic do_ee_write, do_erase, do_fetch, do_latch;
   logic [PM_AW-1:0] pm_addr;
   logic guarded, trig_ok;

   assign pm_addr = {ahi_reg[0], alo_reg};

   // Guarded segment: lowest quarter, half, or all of program memory
   always_comb
   begin
      case (self_program_guard)
         GUARD_NONE: guarded = 1'b0;
         GUARD_QUARTER: guarded = pm_addr < PM_AW'(PM_DEPTH / 4);
         GUARD_HALF: guarded = pm_addr < PM_AW'(PM_DEPTH / 2);
         default: guarded = 1'b1;
      endcase
   end

   // Trigger acceptance: armed keys, permit, idle, timer expired
   assign trig_ok = cpu_wr.ctl_we && cpu_wr.set_trigger
      && key_reg == 2'd2 && st_reg.program_permit
      && state_reg == ST_IDLE && pwrt_done_reg;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      st_next = st_reg;
      key_next = key_reg;
      cnt_next = cnt_reg;
      pwrt_next = pwrt_reg;
      pwrt_done_next = pwrt_done_reg;
      dlo_next = dlo_reg;
      dhi_next = dhi_reg;
      alo_next = alo_reg;
      ahi_next = ahi_reg;
      stall_next = stall_reg;
      do_ee_write = 1'b0;
      do_erase = 1'b0;
      do_fetch = 1'b0;
      do_latch = 1'b0;
      // Power-up timer
      if (!pwrt_done_reg)
      begin
         pwrt_next = pwrt_reg + 23'd1;
         if (pwrt_reg == 23'(PWRT_CNT - 1))
            pwrt_done_next = 1'b1;
      end
      // Key sequence: any other register write disarms
      if (cpu_wr.key_we)
      begin
         if (cpu_wr.key_data == KEY_FIRST)
            key_next = 2'd1;
         else if (cpu_wr.key_data == KEY_SECOND && key_reg == 2'd1)
            key_next = 2'd2;
         else
            key_next = 2'd0;
      end
      else if (cpu_wr.ctl_we || cpu_wr.addr_lo_we || cpu_wr.addr_hi_we
         || cpu_wr.data_lo_we || cpu_wr.data_hi_we)
         key_next = 2'd0;
      // Control write: permit and space selects are plain software bits; row clear is taken only when idle
      if (cpu_wr.ctl_we)
      begin
         st_next.program_permit = cpu_wr.permit;
         st_next.program_space_select = cpu_wr.space_sel;
         st_next.config_space_select = cpu_wr.cfg_sel;
         if (state_reg == ST_IDLE)
            st_next.row_clear_select = cpu_wr.row_clear;
         if (cpu_wr.clear_done)
            st_next.program_done_flag = 1'b0;
         if (cpu_wr.clear_error)
            st_next.interrupted_program_error = 1'b0;
      end
      // Power-up (and device reset) clear permit; hardware never does otherwise
      if (!por_n)
         st_next.program_permit = 1'b0;
      // Register writes; data regs hold fetched word otherwise
      if (cpu_wr.addr_lo_we)
         alo_next = cpu_wr.wdata;
      if (cpu_wr.addr_hi_we)
         ahi_next = cpu_wr.wdata[6:0];
      if (cpu_wr.data_lo_we)
         dlo_next = cpu_wr.wdata;
      if (cpu_wr.data_hi_we)
         dhi_next = cpu_wr.wdata[5:0];
      case (state_reg)
         ST_IDLE:
         begin
            if (trig_ok)
            begin
               key_next = 2'd0;
               st_next.program_trigger = 1'b1;
               cnt_next = '0;
               state_next = st_reg.program_space_select ? ST_SETUP
                  : ST_BUSY;
               if (!st_reg.program_space_select)
                  do_ee_write = 1'b1;
            end
            else if (cpu_wr.ctl_we && cpu_wr.set_fetch)
            begin
               st_next.fetch_trigger = 1'b1;
               cnt_next = '0;
               state_next = ST_FETCH;
            end
         end
         ST_SETUP:
         begin
            // Two setup cycles before the stall begins
            cnt_next = cnt_reg + 23'd1;
            if (cnt_reg == 23'(SETUP_CYCLES - 1))
            begin
               cnt_next = '0;
               if (!st_reg.row_clear_select || guarded)
               begin
                  // Latch load or refused write: no stall
                  if (!st_reg.row_clear_select && !guarded)
                     do_latch = 1'b1;
                  st_next.program_trigger = 1'b0;
                  st_next.program_done_flag = 1'b1;
                  state_next = ST_IDLE;
               end
               else
               begin
                  stall_next = 1'b1;
                  state_next = ST_BUSY;
               end
            end
         end
         ST_BUSY:
         begin
            // Permit is not looked at here, so clearing it cannot abort
            cnt_next = cnt_reg + 23'd1;
            if (cnt_reg == (st_reg.program_space_select
               ? 23'(ERASE_CNT - 1) : 23'(EE_WRITE_CYCLES - 1)))
            begin
               if (st_reg.program_space_select)
               begin
                  do_erase = 1'b1;
                  st_next.row_clear_select = 1'b0;
               end
               stall_next = 1'b0;
               st_next.program_trigger = 1'b0;
               st_next.program_done_flag = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_FETCH:
         begin
            // Second cycle after the trigger performs the read
            cnt_next = cnt_reg + 23'd1;
            if (cnt_reg == 23'd1)
            begin
               do_fetch = 1'b1;
               st_next.fetch_trigger = 1'b0;
               state_next = ST_IDLE;
               if (st_reg.program_space_select)
               begin
                  // Code guard is not consulted on a CPU read
                  dlo_next = pm_mem[pm_addr][7:0];
                  dhi_next = pm_mem[pm_addr][13:8];
               end
               else
                  dlo_next = ee_mem[alo_reg];
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Power-up clears permit; a plain reset mid-write flags the abort
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         st_reg <= '0;
         key_reg <= 2'd0;
         cnt_reg <= '0;
         pwrt_reg <= '0;
         pwrt_done_reg <= 1'b0;
         dlo_reg <= 8'h00;
         dhi_reg <= 6'h00;
         alo_reg <= 8'h00;
         ahi_reg <= 7'h00;
         stall_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         st_reg <= st_next;
         key_reg <= key_next;
         cnt_reg <= cnt_next;
         pwrt_reg <= pwrt_next;
         pwrt_done_reg <= pwrt_done_next;
         dlo_reg <= dlo_next;
         dhi_reg <= dhi_next;
         alo_reg <= alo_next;
         ahi_reg <= ahi_next;
         stall_reg <= stall_next;
      end
   end

   // Write-in-flight marker; device reset clears it only at the clock edge, so the abort is seen
   assign active_next_w = state_next == ST_BUSY
      || (state_next == ST_SETUP);
   always_ff @(posedge sys_clk or negedge por_n)
   begin
      if (!por_n)
         active_reg <= 1'b0;
      else if (!rst_n)
         active_reg <= 1'b0;
      else
         active_reg <= active_next_w;
   end
   assign status = st_reg | {7'h00, (!por_n ? 1'b0 : flag_err_reg)};
   always_ff @(posedge sys_clk or negedge por_n)
   begin
      if (!por_n)
         flag_err_reg <= 1'b0;
      else if (!rst_n && active_reg)
         flag_err_reg <= 1'b1;
      else if (cpu_wr.ctl_we && cpu_wr.clear_error)
         flag_err_reg <= 1'b0;
   end

   // Memory arrays: byte write overwrites, erase fills a whole row
   always_ff @(posedge sys_clk)
   begin
      if (do_ee_write)
         ee_mem[alo_reg] <= dlo_reg;
      if (do_latch)
         latch_mem[pm_addr[ROW_LSB-1:0]] <= {dhi_reg, dlo_reg};
      if (do_erase && !guarded)
         for (int i = 0; i < ROW_WORDS; i++)
            pm_mem[{pm_addr[PM_AW-1:ROW_LSB], 5'(i)}] <= ERASED_WORD;
   end

   // External programmer path: denied when data protect is low
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xd_reg <= 8'h00;
         xden_reg <= 1'b0;
      end
      else
      begin
         xd_reg <= xd_next;
         xden_reg <= xden_next;
      end
   end
   always_comb
   begin
      xd_next = xd_reg;
      xden_next = xden_reg;
      if (ext_read_req)
      begin
         xden_next = !data_protect_n;
         xd_next = data_protect_n ? ee_mem[ext_addr] : 8'h00;
      end
   end

   assign nvm_data_low = dlo_reg;
   assign nvm_data_high = dhi_reg;
   assign nvm_addr_low = alo_reg;
   assign nvm_addr_high = ahi_reg;
   assign cpu_stall = stall_reg;
   assign ext_read_data = xd_reg;
   assign ext_read_denied = xden_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_NO_TRIG_WITHOUT_PERMIT: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $rose(st_reg.program_trigger)
      |-> $past(st_reg.program_permit))
      else $error("trigger set without permit");
   AST_KEYS_BEFORE_TRIG: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $rose(st_reg.program_trigger)
      |-> $past(key_reg) == 2'd2)
      else $error("trigger set without unlock keys");
   AST_DONE_ON_END: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $fell(st_reg.program_trigger)
      |-> st_reg.program_done_flag)
      else $error("write end without done flag");
   AST_DONE_STICKY: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $fell(st_reg.program_done_flag)
      |-> $past(cpu_wr.ctl_we && cpu_wr.clear_done))
      else $error("done flag cleared by hardware");
   AST_PERMIT_SW_ONLY: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $fell(st_reg.program_permit)
      |-> $past(cpu_wr.ctl_we || !por_n))
      else $error("permit cleared by hardware");
   AST_PWRT_BLOCK: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !pwrt_done_reg |-> ##1 !$rose(active_reg))
      else $error("write started under power-up timer");
   AST_FETCH_TWO: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $rose(st_reg.fetch_trigger)
      |-> ##1 st_reg.fetch_trigger ##1 !st_reg.fetch_trigger)
      else $error("fetch not done in second cycle");
   AST_ROW_CLEAR_END: assert property (@(posedge sys_clk)
      disable iff (!rst_n) $fell(stall_reg) && st_reg.program_space_select
      |-> !st_reg.row_clear_select)
      else $error("row clear select kept after erase");
endmodule // nvm_ctrl
`default_nettype wire

/* verification/test_nvm_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Compare helper
// ------------------------------------------------------------
`define CHK(a, b) \
   begin \
      n_tests++; \
      if ((a) !== (b)) \
      begin \
         fails++; \
         $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); \
      end \
   end
module test_nvm_ctrl;
   import nvm_ctrl_pkg::*;
   // Short counts keep the run brief; expectations derive from these
   localparam int PWRT_SIM = 20;
   localparam int ERASE_SIM = 30;
   localparam int DLY = 10;
   // Control write bit order: trig fetch permit space cfg row cdone cerr
   localparam logic [7:0] T_TRIG = 8'h80;
   localparam logic [7:0] T_FETCH = 8'h40;
   localparam logic [7:0] T_PERMIT = 8'h20;
   localparam logic [7:0] T_SPACE = 8'h10;
   localparam logic [7:0] T_ROW = 8'h04;
   localparam logic [7:0] T_CDONE = 8'h02;
   localparam logic [7:0] T_CERR = 8'h01;
   logic sys_clk = 1'b0;
   logic rst_n, por_n, data_protect_n, code_guard_n, ext_read_req;
   logic ext_read_denied, cpu_stall;
   logic [1:0] self_program_guard;
   logic [7:0] ext_addr, ext_read_data, nvm_data_low, nvm_addr_low;
   logic [5:0] nvm_data_high;
   logic [6:0] nvm_addr_high;
   cpu_wr_s cpu_wr;
   nvm_status_s status;
   int fails = 0;
   int n_tests = 0;
   int cnt;

   always #50 sys_clk = ~sys_clk;

   nvm_ctrl #(.PWRT_CNT(PWRT_SIM), .ERASE_CNT(ERASE_SIM)) uut
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .cpu_wr(cpu_wr),
      .self_program_guard(self_program_guard),
      .data_protect_n(data_protect_n), .code_guard_n(code_guard_n),
      .ext_read_req(ext_read_req), .ext_addr(ext_addr), .status(status),
      .nvm_data_low(nvm_data_low), .nvm_data_high(nvm_data_high),
      .nvm_addr_low(nvm_addr_low), .nvm_addr_high(nvm_addr_high),
      .cpu_stall(cpu_stall), .ext_read_data(ext_read_data),
      .ext_read_denied(ext_read_denied)
   );

   // ------------------------------------------------------------
   // Access helpers
   // ------------------------------------------------------------
   function automatic cpu_wr_s key(input logic [7:0] d);
      cpu_wr_s w;
      w = '0;
      w.key_we = 1'b1;
      w.key_data = d;
      return w;
   endfunction

   function automatic cpu_wr_s ctl(input logic [7:0] b);
      cpu_wr_s w;
      w = '0;
      w.ctl_we = 1'b1;
      {w.set_trigger, w.set_fetch, w.permit, w.space_sel, w.cfg_sel,
       w.row_clear, w.clear_done, w.clear_error} = b;
      return w;
   endfunction

   // Selector: 0 addr low, 1 addr high, 2 data low, 3 data high
   function automatic cpu_wr_s regw(input int sel, input logic [7:0] d);
      cpu_wr_s w;
      w = '0;
      w.addr_lo_we = (sel == 0);
      w.addr_hi_we = (sel == 1);
      w.data_lo_we = (sel == 2);
      w.data_hi_we = (sel == 3);
      w.wdata = d;
      return w;
   endfunction

   // One-cycle strobe, then an idle cycle so no signal is driven twice
   task automatic put(input cpu_wr_s v);
      cpu_wr = v;
      @(posedge sys_clk);
      #DLY;
      cpu_wr = '0;
      @(posedge sys_clk);
      #DLY;
   endtask

   task automatic unlock(input logic [7:0] b);
      put(key(KEY_FIRST));
      put(key(KEY_SECOND));
      put(ctl(b | T_TRIG));
   endtask

   // Bounded wait for a trigger bit to drop
   task automatic wait_idle(input bit fetch);
      int i;
      i = 0;
      while ((fetch ? status.fetch_trigger : status.program_trigger)
             !== 1'b0 && i < 200)
      begin
         @(posedge sys_clk);
         #DLY;
         i++;
      end
      if (i >= 200)
      begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic ext_rd(input logic [7:0] a, input logic prot,
                         input logic den, input logic [7:0] d);
      data_protect_n = prot;
      ext_addr = a;
      ext_read_req = 1'b1;
      @(posedge sys_clk);
      #DLY;
      ext_read_req = 1'b0;
      `CHK(ext_read_denied, den)
      if (den === 1'b0)
         `CHK(ext_read_data, d)
   endtask

   task automatic done_test(input string s);
      $display("finished: %s", s);
   endtask

   task automatic tally_and_finish();
      $display("compares=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard well beyond the longest sequence
   initial
   begin
      #5000000;
      fails++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst_n, por_n, ext_read_req, ext_addr} = '0;
      {data_protect_n, code_guard_n} = 2'h3;
      self_program_guard = GUARD_NONE;
      cpu_wr = '0;
      repeat (5) @(posedge sys_clk);
      #DLY;
      {rst_n, por_n} = 2'h3;
      `CHK(status, nvm_status_s'(8'h00))
      `CHK(cpu_stall, 1'b0)
      done_test("reset");
      // Full unlock while the power-up timer still runs
      put(regw(0, 8'h3C));
      put(regw(2, 8'hA5));
      put(ctl(T_PERMIT));
      unlock(T_PERMIT);
      `CHK(status.program_trigger, 1'b0)
      repeat (PWRT_SIM) @(posedge sys_clk);
      #DLY;
      done_test("power-up block");
      put(ctl(8'h00));
      unlock(8'h00);
      `CHK(status.program_trigger, 1'b0)
      put(ctl(T_PERMIT));
      put(key(KEY_SECOND));
      put(key(KEY_FIRST));
      put(ctl(T_PERMIT | T_TRIG));
      `CHK(status.program_trigger, 1'b0)
      put(key(KEY_FIRST));
      put(regw(0, 8'h3C));
      put(key(KEY_SECOND));
      put(ctl(T_PERMIT | T_TRIG));
      `CHK(status.program_trigger, 1'b0)
      done_test("refused triggers");
      unlock(T_PERMIT);
      `CHK(status.program_trigger, 1'b1)
      wait_idle(1'b0);
      `CHK(status.program_done_flag, 1'b1)
      `CHK(status.program_permit, 1'b1)
      repeat (10) @(posedge sys_clk);
      #DLY;
      `CHK(status.program_done_flag, 1'b1)
      put(ctl(T_PERMIT | T_CDONE));
      `CHK(status.program_done_flag, 1'b0)
      // Second byte, permit dropped mid-write
      put(regw(0, 8'h3D));
      put(regw(2, 8'h5A));
      unlock(T_PERMIT);
      put(ctl(8'h00));
      `CHK(status.program_trigger, 1'b1)
      `CHK(status.program_permit, 1'b0)
      wait_idle(1'b0);
      `CHK(status.program_done_flag, 1'b1)
      put(ctl(T_CDONE));
      put(regw(0, 8'h3C));
      put(ctl(T_FETCH));
      wait_idle(1'b1);
      `CHK(nvm_data_low, 8'hA5)
      ext_rd(8'h3D, 1'b1, 1'b0, 8'h5A);
      ext_rd(8'h3D, 1'b0, 1'b1, 8'h00);
      done_test("data writes");
      // Row erase with stall measurement
      code_guard_n = 1'b0;
      put(regw(1, 8'h00));
      put(regw(0, 8'h40));
      put(ctl(T_SPACE | T_ROW | T_PERMIT));
      unlock(T_SPACE | T_ROW | T_PERMIT);
      cnt = 0;
      for (int i = 0; i < 300; i++)
      begin
         @(posedge sys_clk);
         #DLY;
         if (cpu_stall === 1'b1)
            cnt++;
         if (cnt > 0 && cpu_stall === 1'b0) break;
      end
      `CHK(cnt, ERASE_SIM)
      wait_idle(1'b0);
      `CHK(status.row_clear_select, 1'b0)
      `CHK(status.program_done_flag, 1'b1)
      put(ctl(T_SPACE | T_PERMIT | T_CDONE));
      put(regw(0, 8'h5F));
      put(ctl(T_SPACE | T_PERMIT | T_FETCH));
      wait_idle(1'b1);
      `CHK({nvm_data_high, nvm_data_low}, ERASED_WORD)
      put(regw(2, 8'h12));
      `CHK(nvm_data_low, 8'h12)
      `CHK(nvm_data_high, 6'h3F)
      done_test("row erase and fetch");
      // Erase into a guarded segment must never stall
      self_program_guard = 2'h0;
      put(regw(0, 8'h40));
      put(ctl(T_SPACE | T_ROW | T_PERMIT));
      unlock(T_SPACE | T_ROW | T_PERMIT);
      cnt = 0;
      repeat (ERASE_SIM + 10)
      begin
         @(posedge sys_clk);
         if (cpu_stall === 1'b1)
            cnt++;
      end
      #DLY;
      `CHK(cnt, 0)
      wait_idle(1'b0);
      self_program_guard = GUARD_NONE;
      put(ctl(T_PERMIT | T_CDONE));
      done_test("guarded erase");
      // Device reset in the middle of a byte write
      put(regw(0, 8'h3E));
      put(regw(2, 8'h11));
      unlock(T_PERMIT);
      repeat (5) @(posedge sys_clk);
      #DLY;
      rst_n = 1'b0;
      @(posedge sys_clk);
      #DLY;
      rst_n = 1'b1;
      `CHK(status.interrupted_program_error, 1'b1)
      put(ctl(T_CERR));
      `CHK(status.interrupted_program_error, 1'b0)
      put(ctl(T_PERMIT));
      por_n = 1'b0;
      @(posedge sys_clk);
      #DLY;
      por_n = 1'b1;
      `CHK(status.program_permit, 1'b0)
      done_test("interrupted write");
      tally_and_finish();
   end
endmodule // test_nvm_ctrl
`default_nettype wire
